// *** smbus_mem_defs.vh ***
// Constants for the SMBus access path to register RAM and paged nonvolatile memory
//
// Summary of operation
// - Write byte to RAM command stores one byte
// - Nonvolatile command plus byte latches 16-bit pointer
// - Erase picks page from pointer bits 9:5
// - Write word programs second byte at pointer
// - Acknowledge address and every received byte
// - Block write starts at previously set pointer
// - Block write takes count then up to 32
// - Hold SCL low while byte cannot be accepted
// - Receive byte returns data at current pointer
// - Block read command then repeated start read
// - Block read sends count 32, then 32 bytes
// - Optional check byte accepted after written data
// - Check byte is CRC-8, polynomial 0x07
// - Slave address 10001 plus two select pins
// - Send byte in RAM range sets pointer
// - Erase command erases only when enabled
// - Refuse every access while page erase runs
`ifndef SMBUS_MEM_DEFS_VH
`define SMBUS_MEM_DEFS_VH

// ****************************************
// Addressing, command codes and data values
// ****************************************
`define ADDR_FIXED        5'h11
`define RAM_TOP           8'hDF
`define EE_HI_MIN         8'hF8
`define EE_HI_MAX         8'hFB
`define EE_REGION         6'h3E
`define CMD_BLK_WR        8'hFC
`define CMD_BLK_RD        8'hFD
`define CMD_ERASE         8'hFE
`define BLK_MAX           8'h20
`define BLK_LAST_IDX      6'h20
`define BLK_PEC_IDX       6'h21
`define UPD_CFG_ADDR      8'h90
`define ERASE_EN_BIT      2
`define PAGE_LAST         5'h1F
`define ERASED_BYTE       8'hFF
`define IDLE_BYTE         8'hFF
`define CRC_POLY          8'h07

// ****************************************
// Write queue entry kinds
// ****************************************
`define KIND_RAM          2'h0
`define KIND_EE           2'h1
`define KIND_ERASE        2'h2

// ****************************************
// Timing
// ****************************************
`define CLK_FREQ_MHZ      125
`define PROG_TIME_US      250
`define ERASE_TIME_MS     20
`define PROG_CYCLES       (`PROG_TIME_US * `CLK_FREQ_MHZ)
`define ERASE_CYCLES      (`ERASE_TIME_MS * 1000 * `CLK_FREQ_MHZ)

`endif

// *** smbus_write_fifo.v ***
// Small write queue between the bus side and the memory programming engine
`timescale 1ns/1ns
`default_nettype none

module smbus_write_fifo #(
  parameter WIDTH = 26,
  parameter DEPTH = 4,
  parameter PTR_W = 2
) (
  input  wire             clk,
  input  wire             rst_n,
  input  wire             in_valid,
  output wire             in_ready,
  input  wire [WIDTH-1:0] in_data,
  output wire             out_valid,
  input  wire             out_ready,
  output wire [WIDTH-1:0] out_data
);

  reg [WIDTH-1:0] store [0:DEPTH-1];
  reg [PTR_W-1:0] wr_ptr;
  reg [PTR_W-1:0] rd_ptr;
  reg [PTR_W:0]   fill;

  wire push = in_valid & in_ready;
  wire pop  = out_valid & out_ready;

  assign in_ready  = (fill != DEPTH[PTR_W:0]);
  assign out_valid = (fill != {(PTR_W+1){1'b0}});
  assign out_data  = store[rd_ptr];

  always @(posedge clk) begin
    if (push) begin
      store[wr_ptr] <= in_data;
    end
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr <= {PTR_W{1'b0}};
      rd_ptr <= {PTR_W{1'b0}};
      fill   <= {(PTR_W+1){1'b0}};
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == DEPTH[PTR_W-1:0] - 1'b1) ? {PTR_W{1'b0}} : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == DEPTH[PTR_W-1:0] - 1'b1) ? {PTR_W{1'b0}} : rd_ptr + 1'b1;
      end
      if (push & ~pop) begin
        fill <= fill + 1'b1;
      end else if (pop & ~push) begin
        fill <= fill - 1'b1;
      end
    end
  end

endmodule

`default_nettype wire

// *** smbus_byte_mem.v ***
// Byte-wide storage with one write port and one registered read port
`timescale 1ns/1ns
`default_nettype none

module smbus_byte_mem #(
  parameter DATA_W = 8,
  parameter ADDR_W = 8
) (
  input  wire              clk,
  input  wire              wr_en,
  input  wire [ADDR_W-1:0] wr_addr,
  input  wire [DATA_W-1:0] wr_data,
  input  wire [ADDR_W-1:0] rd_addr,
  output reg  [DATA_W-1:0] rd_data
);

  reg [DATA_W-1:0] cells [0:(1<<ADDR_W)-1];

  always @(posedge clk) begin
    if (wr_en) begin
      cells[wr_addr] <= wr_data;
    end
    rd_data <= cells[rd_addr];
  end

endmodule

`default_nettype wire

// *** smbus_ram_eeprom_access.v ***
// SMBus slave giving access to register RAM and paged nonvolatile memory
`timescale 1ns/1ns
`default_nettype none
`include "smbus_mem_defs.vh"

module smbus_ram_eeprom_access #(
  parameter PROG_CYCLES  = `PROG_CYCLES,
  parameter ERASE_CYCLES = `ERASE_CYCLES,
  parameter FIFO_DEPTH   = 4,
  parameter TIMER_W      = 22
) (
  input  wire clk,
  input  wire reset_n,
  input  wire scl_in,
  input  wire sda_in,
  input  wire address_select_high_pin,
  input  wire address_select_low_pin,
  output reg  scl_out,
  output reg  scl_oe,
  output reg  sda_out,
  output reg  sda_oe
);

  // ****************************************
  // Bus states and engine states
  // ****************************************
  localparam [6:0] ST_IDLE  = 7'h01;
  localparam [6:0] ST_ADDR  = 7'h02;
  localparam [6:0] ST_RX    = 7'h04;
  localparam [6:0] ST_WAIT  = 7'h08;
  localparam [6:0] ST_ACK   = 7'h10;
  localparam [6:0] ST_TX    = 7'h20;
  localparam [6:0] ST_TXACK = 7'h40;

  localparam [3:0] ENG_IDLE  = 4'h1;
  localparam [3:0] ENG_PROG  = 4'h2;
  localparam [3:0] ENG_ERASE = 4'h4;
  localparam [3:0] ENG_EWAIT = 4'h8;

  localparam integer       PROG_LAST  = PROG_CYCLES - 1;
  localparam integer       ERASE_LAST = ERASE_CYCLES - 1;
  localparam [TIMER_W-1:0] PROG_LOAD  = PROG_LAST[TIMER_W-1:0];
  localparam [TIMER_W-1:0] ERASE_LOAD = ERASE_LAST[TIMER_W-1:0];

  // ****************************************
  // Reset release and pin synchronisers
  // ****************************************
  reg [1:0] rst_pipe;
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_pipe <= 2'h0;
    end else begin
      rst_pipe <= {rst_pipe[0], 1'b1};
    end
  end
  wire rst_n = rst_pipe[1];

  reg [3:0] pin_meta;
  reg [3:0] pin_sync;
  reg       scl_prev;
  reg       sda_prev;
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_meta <= 4'hF;
      pin_sync <= 4'hF;
      scl_prev <= 1'b1;
      sda_prev <= 1'b1;
    end else begin
      pin_meta <= {scl_in, sda_in, address_select_high_pin, address_select_low_pin};
      pin_sync <= pin_meta;
      scl_prev <= pin_sync[3];
      sda_prev <= pin_sync[2];
    end
  end

  wire scl       = pin_sync[3];
  wire sda       = pin_sync[2];
  wire scl_rise  = scl & ~scl_prev;
  wire scl_fall  = ~scl & scl_prev;
  wire bus_start = scl & scl_prev & sda_prev & ~sda;
  wire bus_stop  = scl & scl_prev & ~sda_prev & sda;

  // ****************************************
  // Transaction registers
  // ****************************************
  reg [6:0]  state;
  reg [3:0]  bit_cnt;
  reg [7:0]  shift;
  reg [5:0]  byte_idx;
  reg [7:0]  cmd;
  reg [7:0]  count;
  reg [15:0] ptr;
  reg        read_mode;
  reg        blk_armed;
  reg [5:0]  tx_idx;
  reg [7:0]  tx_shift;
  reg        nack;
  reg        acked;
  reg [7:0]  crc;

  reg [3:0]         eng_state;
  reg [TIMER_W-1:0] timer;
  reg [4:0]         page;
  reg [4:0]         erase_cnt;
  reg               busy_erase;
  reg               erase_en;
  reg               ram_we;
  reg [7:0]         ram_waddr;
  reg [7:0]         ram_wdata;
  reg               ee_we;
  reg [9:0]         ee_waddr;
  reg [7:0]         ee_wdata;

  wire [7:0]  ram_rd;
  wire [7:0]  ee_rd;
  wire        fifo_in_ready;
  wire        fifo_out_valid;
  wire [25:0] fifo_out;
  wire        eng_busy = (eng_state != ENG_IDLE);

  function [7:0] crc8;
    input [7:0] c;
    input [7:0] d;
    integer     i;
    reg   [7:0] r;
    begin
      r = c ^ d;
      for (i = 0; i < 8; i = i + 1) begin
        r = r[7] ? ({r[6:0], 1'b0} ^ `CRC_POLY) : {r[6:0], 1'b0};
      end
      crc8 = r;
    end
  endfunction

  // ****************************************
  // Byte decode
  // ****************************************
  wire addr_match = (shift[7:1] == {`ADDR_FIXED, pin_sync[1], pin_sync[0]});
  wire cmd_ram    = (cmd <= `RAM_TOP);
  wire cmd_ee     = (cmd >= `EE_HI_MIN) && (cmd <= `EE_HI_MAX);
  wire ptr_ram    = (ptr[15:8] == 8'h00) && (ptr[7:0] <= `RAM_TOP);
  wire ptr_ee     = (ptr[15:10] == `EE_REGION);
  wire blk_data   = (cmd == `CMD_BLK_WR) && (byte_idx >= 6'd3) &&
                    (count <= `BLK_MAX) && (({2'b00, byte_idx} - 8'd2) <= count);

  reg        push_req;
  reg [1:0]  push_kind;
  reg [15:0] push_addr;
  always @* begin
    push_req  = 1'b0;
    push_kind = `KIND_RAM;
    push_addr = ptr;
    if (byte_idx == 6'd1) begin
      if ((shift == `CMD_ERASE) && erase_en && ptr_ee && !busy_erase) begin
        push_req  = 1'b1;
        push_kind = `KIND_ERASE;
      end
    end else if (byte_idx == 6'd2) begin
      if (cmd_ram) begin
        push_req  = 1'b1;
        push_addr = {8'h00, cmd};
      end
    end else if ((byte_idx == 6'd3) && cmd_ee) begin
      push_req  = ptr_ee;
      push_kind = `KIND_EE;
    end
    if (blk_data) begin
      push_req  = ptr_ram | ptr_ee;
      push_kind = ptr_ee ? `KIND_EE : `KIND_RAM;
    end
  end

  // Read path waits for queued writes so a read never returns stale data
  // A read during an erase is refused at once instead of being held for the erase time
  wire rx_stall = (push_req & ~fifo_in_ready) |
                  ((byte_idx == 6'd0) & shift[0] & addr_match & ~busy_erase &
                   (fifo_out_valid | eng_busy));
  wire rx_done  = scl_fall & ((state == ST_ADDR) | (state == ST_RX)) & (bit_cnt == 4'd8);
  wire take     = (rx_done | (state == ST_WAIT)) & ~rx_stall;
  wire fifo_push = take & push_req;

  wire [7:0] rd_byte = ptr_ee ? ee_rd : (ptr_ram ? ram_rd : `IDLE_BYTE);
  reg  [7:0] tx_byte;
  always @* begin
    if (!blk_armed) begin
      tx_byte = rd_byte;
    end else if (tx_idx == 6'd0) begin
      tx_byte = `BLK_MAX;
    end else if (tx_idx <= `BLK_LAST_IDX) begin
      tx_byte = rd_byte;
    end else if (tx_idx == `BLK_PEC_IDX) begin
      tx_byte = crc;
    end else begin
      tx_byte = `IDLE_BYTE;
    end
  end
  wire load = scl_fall & (((state == ST_ACK) & acked & read_mode) |
                          ((state == ST_TXACK) & ~nack));

  // ****************************************
  // Bus state machine
  // ****************************************
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state     <= ST_IDLE;
      bit_cnt   <= 4'h0;
      shift     <= 8'h00;
      byte_idx  <= 6'h00;
      cmd       <= 8'h00;
      count     <= 8'h00;
      ptr       <= 16'h0000;
      read_mode <= 1'b0;
      blk_armed <= 1'b0;
      tx_idx    <= 6'h00;
      tx_shift  <= 8'h00;
      nack      <= 1'b0;
      acked     <= 1'b0;
      crc       <= 8'h00;
      scl_oe    <= 1'b0;
      sda_oe    <= 1'b0;
      scl_out   <= 1'b0;
      sda_out   <= 1'b0;
    end else if (bus_start) begin
      state    <= ST_ADDR;
      bit_cnt  <= 4'h0;
      byte_idx <= 6'h00;
      scl_oe   <= 1'b0;
      sda_oe   <= 1'b0;
    end else if (bus_stop) begin
      state     <= ST_IDLE;
      blk_armed <= 1'b0;
      read_mode <= 1'b0;
      crc       <= 8'h00;
      scl_oe    <= 1'b0;
      sda_oe    <= 1'b0;
    end else begin
      case (state)
        ST_ADDR, ST_RX, ST_WAIT: begin
          if (scl_rise && state != ST_WAIT) begin
            shift   <= {shift[6:0], sda};
            bit_cnt <= bit_cnt + 4'd1;
          end
          if (take) begin
            scl_oe   <= 1'b0;
            state    <= ST_ACK;
            byte_idx <= (byte_idx == 6'h3F) ? byte_idx : byte_idx + 6'd1;
            if (byte_idx == 6'd0) begin
              acked     <= addr_match & ~busy_erase;
              sda_oe    <= addr_match & ~busy_erase;
              read_mode <= shift[0];
              tx_idx    <= 6'h00;
              if (addr_match) begin
                crc <= crc8(crc, shift);
              end
            end else begin
              acked  <= 1'b1;
              sda_oe <= 1'b1;
              crc    <= crc8(crc, shift);
              if (byte_idx == 6'd1) begin
                cmd <= shift;
                if (shift <= `RAM_TOP) begin
                  ptr <= {8'h00, shift};
                end
                if (shift == `CMD_BLK_RD) begin
                  blk_armed <= 1'b1;
                end
              end else if (byte_idx == 6'd2) begin
                if (cmd_ee) begin
                  ptr <= {cmd, shift};
                end
                if (cmd == `CMD_BLK_WR) begin
                  count <= shift;
                end
              end
              if (blk_data) begin
                ptr <= ptr + 16'd1;
              end
            end
          end else if (rx_done) begin
            state  <= ST_WAIT;
            scl_oe <= 1'b1;
          end
        end
        ST_ACK, ST_TXACK: begin
          if (scl_rise && state == ST_TXACK) begin
            nack <= sda;
          end
          if (load) begin
            sda_oe   <= ~tx_byte[7];
            tx_shift <= {tx_byte[6:0], 1'b0};
            bit_cnt  <= 4'h0;
            crc      <= crc8(crc, tx_byte);
            tx_idx   <= (tx_idx == 6'h3F) ? tx_idx : tx_idx + 6'd1;
            state    <= ST_TX;
            if (blk_armed && tx_idx != 6'd0 && tx_idx <= `BLK_LAST_IDX) begin
              ptr <= ptr + 16'd1;
            end
          end else if (scl_fall) begin
            sda_oe  <= 1'b0;
            bit_cnt <= 4'h0;
            if (state == ST_TXACK || !acked) begin
              state <= ST_IDLE;
            end else begin
              state <= ST_RX;
            end
          end
        end
        ST_TX: begin
          if (scl_rise) begin
            bit_cnt <= bit_cnt + 4'd1;
          end
          if (scl_fall) begin
            if (bit_cnt == 4'd8) begin
              sda_oe <= 1'b0;
              state  <= ST_TXACK;
            end else begin
              sda_oe   <= ~tx_shift[7];
              tx_shift <= {tx_shift[6:0], 1'b0};
            end
          end
        end
        default: begin
          sda_oe <= 1'b0;
          scl_oe <= 1'b0;
        end
      endcase
    end
  end

  // ****************************************
  // Write queue and memory engine
  // ****************************************
  smbus_write_fifo #(
    .WIDTH (26),
    .DEPTH (FIFO_DEPTH),
    .PTR_W (2)
  ) u_fifo (
    .clk       (clk),
    .rst_n     (rst_n),
    .in_valid  (fifo_push),
    .in_ready  (fifo_in_ready),
    .in_data   ({push_kind, push_addr, shift}),
    .out_valid (fifo_out_valid),
    .out_ready (~eng_busy),
    .out_data  (fifo_out)
  );

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      eng_state  <= ENG_IDLE;
      timer      <= {TIMER_W{1'b0}};
      page       <= 5'h00;
      erase_cnt  <= 5'h00;
      busy_erase <= 1'b0;
      erase_en   <= 1'b0;
      ram_we     <= 1'b0;
      ram_waddr  <= 8'h00;
      ram_wdata  <= 8'h00;
      ee_we      <= 1'b0;
      ee_waddr   <= 10'h000;
      ee_wdata   <= 8'h00;
    end else begin
      ram_we <= 1'b0;
      ee_we  <= 1'b0;
      case (eng_state)
        ENG_IDLE: begin
          if (fifo_out_valid) begin
            if (fifo_out[25:24] == `KIND_RAM) begin
              ram_we    <= 1'b1;
              ram_waddr <= fifo_out[15:8];
              ram_wdata <= fifo_out[7:0];
              if (fifo_out[15:8] == `UPD_CFG_ADDR) begin
                erase_en <= fifo_out[`ERASE_EN_BIT];
              end
            end else if (fifo_out[25:24] == `KIND_EE) begin
              ee_we     <= 1'b1;
              ee_waddr  <= fifo_out[17:8];
              ee_wdata  <= fifo_out[7:0];
              timer     <= PROG_LOAD;
              eng_state <= ENG_PROG;
            end else begin
              page      <= fifo_out[17:13];
              erase_cnt <= 5'h00;
              eng_state <= ENG_ERASE;
            end
          end
        end
        ENG_ERASE: begin
          ee_we     <= 1'b1;
          ee_waddr  <= {page, erase_cnt};
          ee_wdata  <= `ERASED_BYTE;
          erase_cnt <= erase_cnt + 5'd1;
          if (erase_cnt == `PAGE_LAST) begin
            timer     <= ERASE_LOAD;
            eng_state <= ENG_EWAIT;
          end
        end
        default: begin
          // Programming time paces the queue, which in turn stretches the bus
          if (timer == {TIMER_W{1'b0}}) begin
            eng_state <= ENG_IDLE;
            if (eng_state == ENG_EWAIT) begin
              busy_erase <= 1'b0;
            end
          end else begin
            timer <= timer - 1'b1;
          end
        end
      endcase
      if (fifo_push && push_kind == `KIND_ERASE) begin
        busy_erase <= 1'b1;
      end
    end
  end

  smbus_byte_mem #(
    .DATA_W (8),
    .ADDR_W (8)
  ) u_ram (
    .clk     (clk),
    .wr_en   (ram_we),
    .wr_addr (ram_waddr),
    .wr_data (ram_wdata),
    .rd_addr (ptr[7:0]),
    .rd_data (ram_rd)
  );

  smbus_byte_mem #(
    .DATA_W (8),
    .ADDR_W (10)
  ) u_ee (
    .clk     (clk),
    .wr_en   (ee_we),
    .wr_addr (ee_waddr),
    .wr_data (ee_wdata),
    .rd_addr (ptr[9:0]),
    .rd_data (ee_rd)
  );

endmodule

`default_nettype wire

// *** smbus_ram_eeprom_access_properties.sv ***
// Pin-level checks for the SMBus RAM and nonvolatile access block
`timescale 1ns/1ns
`default_nettype none

module smbus_ram_eeprom_access_checker #(
  parameter int PROG_CYCLES = 20,
  parameter int FIFO_DEPTH  = 4
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic scl_out,
  input wire logic scl_oe,
  input wire logic sda_out,
  input wire logic sda_oe
);
  // ****************************************
  // Properties
  // ****************************************
  // Reads may wait for every queued byte plus the one in progress
  localparam int STRETCH_MAX = (FIFO_DEPTH + 2) * PROG_CYCLES + 64;
  logic [31:0] stretch_len;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      stretch_len <= 32'h0;
    end else if (scl_oe) begin
      stretch_len <= stretch_len + 32'h1;
    end else begin
      stretch_len <= 32'h0;
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);

  sequence s_start;
    scl_in && $past(scl_in) && $fell(sda_in);
  endsequence

  sequence s_stop;
    scl_in && $past(scl_in) && $rose(sda_in);
  endsequence

  a_pins_pull_low: assert property (scl_out == 1'b0 && sda_out == 1'b0)
    else $error("open-drain data level not low");
  a_stretch_scl_low: assert property ($rose(scl_oe) |-> !$past(scl_in))
    else $error("clock stretch began while SCL high");
  a_sda_moves_low: assert property ($changed(sda_oe) |-> !$past(scl_in))
    else $error("SDA drive changed while SCL high");
  a_ack_late_low: assert property ($rose(sda_oe) |-> !$past(scl_in, 3))
    else $error("SDA pulled too soon after SCL fall");
  a_no_stretch_start: assert property (s_start |=> !scl_oe [*6])
    else $error("SCL held right after START");
  a_quiet_after_stop: assert property (s_stop |=> (!sda_oe && !scl_oe) [*6])
    else $error("bus driven after STOP");
  a_reset_quiet: assert property ($rose(reset_n) |-> (!sda_oe && !scl_oe) [*3])
    else $error("bus driven after reset release");
  a_stretch_bounded: assert property (stretch_len <= STRETCH_MAX)
    else $error("clock stretch too long");
endmodule

bind smbus_ram_eeprom_access smbus_ram_eeprom_access_checker #(
  .PROG_CYCLES(PROG_CYCLES),
  .FIFO_DEPTH (FIFO_DEPTH)
) i_checker (
  .clk    (clk),
  .reset_n(reset_n),
  .scl_in (scl_in),
  .sda_in (sda_in),
  .scl_out(scl_out),
  .scl_oe (scl_oe),
  .sda_out(sda_out),
  .sda_oe (sda_oe)
);

`default_nettype wire

// *** smbus_master_model.sv ***
// Open-drain SMBus master model with clock-stretch awareness
`timescale 1ns/1ns
`default_nettype none

module smbus_master_model (
  input  wire logic clk,
  input  wire logic scl,
  input  wire logic sda,
  output var  logic scl_pull,
  output var  logic sda_pull
);
  // ****************************************
  // Bit and frame tasks, 10 clk per SCL period
  // ****************************************
  int stretch_cycles;

  initial begin
    scl_pull = 1'b0;
    sda_pull = 1'b0;
    stretch_cycles = 0;
  end

  task automatic wait_clk(input int n);
    repeat (n) @(negedge clk);
  endtask

  // Wait out a slave holding SCL low, bounded so a stuck slave cannot hang us
  task automatic scl_high();
    int n;
    n = 0;
    scl_pull = 1'b0;
    @(negedge clk);
    while (!scl && n < 20000) begin
      n++;
      stretch_cycles++;
      @(negedge clk);
    end
  endtask

  task automatic bit_cycle(input logic b, output logic s);
    wait_clk(3);
    sda_pull = !b;
    wait_clk(3);
    scl_high();
    wait_clk(1);
    s = sda;
    wait_clk(2);
    scl_pull = 1'b1;
  endtask

  task automatic do_start();
    sda_pull = 1'b0;
    wait_clk(3);
    scl_high();
    wait_clk(3);
    sda_pull = 1'b1;
    wait_clk(4);
    scl_pull = 1'b1;
  endtask

  task automatic do_stop();
    wait_clk(3);
    sda_pull = 1'b1;
    wait_clk(3);
    scl_high();
    wait_clk(3);
    sda_pull = 1'b0;
    wait_clk(10);
  endtask

  task automatic send_byte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_cycle(b[i], s);
    end
    bit_cycle(1'b1, s);
    ack = !s;
  endtask

  task automatic recv_byte(input logic last, output logic [7:0] b);
    logic s;
    b = 8'h00;
    for (int i = 0; i < 8; i++) begin
      bit_cycle(1'b1, s);
      b = {b[6:0], s};
    end
    bit_cycle(last, s);
  endtask
endmodule

`default_nettype wire

// *** tb_smbus_ram_eeprom_access.sv ***
// Self-checking bench for the SMBus RAM and nonvolatile access block
`timescale 1ns/1ns
`default_nettype none

module tb_smbus_ram_eeprom_access;
  // ****************************************
  // Bench
  // ****************************************
  localparam logic [7:0] DEV_W = 8'h8C;
  localparam logic [7:0] DEV_R = 8'h8D;

  logic       clk;
  logic       reset_n;
  logic       pin_hi;
  logic       pin_lo;
  logic       scl_pull;
  logic       sda_pull;
  logic       scl_out;
  logic       scl_oe;
  logic       sda_out;
  logic       sda_oe;
  logic       scl;
  logic       sda;
  int         num_errors;
  int         total_checks;
  logic [7:0] crc;
  logic [7:0] q[$];

  assign scl = !((scl_oe && !scl_out) || scl_pull);
  assign sda = !((sda_oe && !sda_out) || sda_pull);

  smbus_ram_eeprom_access #(.PROG_CYCLES(400), .ERASE_CYCLES(200), .FIFO_DEPTH(4),
    .TIMER_W(22)) i_smbus_ram_eeprom_access (.clk(clk), .reset_n(reset_n),
    .scl_in(scl), .sda_in(sda), .address_select_high_pin(pin_hi),
    .address_select_low_pin(pin_lo), .scl_out(scl_out), .scl_oe(scl_oe),
    .sda_out(sda_out), .sda_oe(sda_oe));

  smbus_master_model i_smbus_master_model (.clk(clk), .scl(scl), .sda(sda),
    .scl_pull(scl_pull), .sda_pull(sda_pull));

  task automatic chk1(input logic got, input logic exp);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %0t flag %b expected %b", $time, got, exp);
    end
  endtask

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %0t byte %h expected %h", $time, got, exp);
    end
  endtask

  function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] d);
    logic [7:0] r;
    r = c ^ d;
    for (int i = 0; i < 8; i++) begin
      r = r[7] ? ({r[6:0], 1'b0} ^ 8'h07) : {r[6:0], 1'b0};
    end
    return r;
  endfunction

  task automatic put(input logic [7:0] b);
    logic a;
    i_smbus_master_model.send_byte(b, a);
    chk1(a, 1'b1);
    crc = crc8(crc, b);
  endtask

  task automatic get(input logic last, input logic [7:0] exp);
    logic [7:0] b;
    i_smbus_master_model.recv_byte(last, b);
    chk8(b, exp);
    crc = crc8(crc, b);
  endtask

  task automatic wr_q(input logic [7:0] v[$]);
    crc = 8'h00;
    i_smbus_master_model.do_start();
    put(DEV_W);
    foreach (v[i]) begin
      put(v[i]);
    end
    i_smbus_master_model.do_stop();
  endtask

  task automatic rd1(input logic [7:0] exp);
    i_smbus_master_model.do_start();
    put(DEV_R);
    get(1'b1, exp);
    i_smbus_master_model.do_stop();
  endtask

  task automatic probe(input logic [7:0] a, output logic ack);
    i_smbus_master_model.do_start();
    i_smbus_master_model.send_byte(a, ack);
    i_smbus_master_model.do_stop();
  endtask

  task automatic t_addr();
    logic a;
    for (int p = 0; p < 4; p++) begin
      {pin_hi, pin_lo} = 2'(p);
      for (int i = 0; i < 4; i++) begin
        probe(8'h88 | 8'(i << 1), a);
        chk1(a, i == p);
      end
    end
    {pin_hi, pin_lo} = 2'h2;
    $display("test address done");
  endtask

  task automatic t_ram();
    wr_q('{8'h10, 8'h3C});
    wr_q('{8'h11, 8'hC3, crc8(crc8(crc8(8'h00, DEV_W), 8'h11), 8'hC3)});
    wr_q('{8'h10});
    rd1(8'h3C);
    wr_q('{8'h11});
    rd1(8'hC3);
    $display("test ram done");
  endtask

  task automatic t_block();
    q = '{8'hFC, 8'h20};
    for (int i = 0; i < 32; i++) begin
      q.push_back(8'(i) ^ 8'hA5);
    end
    wr_q('{8'h40});
    wr_q(q);
    wr_q('{8'h40});
    crc = 8'h00;
    i_smbus_master_model.do_start();
    put(DEV_W);
    put(8'hFD);
    i_smbus_master_model.do_start();
    put(DEV_R);
    get(1'b0, 8'h20);
    for (int i = 0; i < 32; i++) begin
      get(1'b0, q[i + 2]);
    end
    get(1'b1, crc);
    i_smbus_master_model.do_stop();
    $display("test block done");
  endtask

  task automatic t_ee();
    logic a;
    int   n;
    wr_q('{8'h90, 8'h04});
    wr_q('{8'hF9, 8'h3B});
    wr_q('{8'hFE});
    probe(DEV_R, a);
    chk1(a, 1'b0);
    n = 0;
    while (!a && n < 300) begin
      probe(DEV_W, a);
      n++;
    end
    chk1(a, 1'b1);
    wr_q('{8'hF9, 8'h21});
    rd1(8'hFF);
    wr_q('{8'hF9, 8'h24, 8'h5A});
    wr_q('{8'hF9, 8'h28});
    n = i_smbus_master_model.stretch_cycles;
    // Eight bytes outrun the programming engine, so the queue must fill
    wr_q('{8'hFC, 8'h08, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07, 8'h08});
    chk1(i_smbus_master_model.stretch_cycles > n, 1'b1);
    wr_q('{8'hF9, 8'h24});
    rd1(8'h5A);
    wr_q('{8'hF9, 8'h2F});
    rd1(8'h08);
    wr_q('{8'h90, 8'h00});
    wr_q('{8'hF9, 8'h24});
    wr_q('{8'hFE});
    rd1(8'h5A);
    $display("test nonvolatile done");
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  initial begin
    num_errors = 0;
    total_checks = 0;
    crc = 8'h00;
    reset_n = 1'b0;
    pin_hi = 1'b1;
    pin_lo = 1'b0;
    repeat (6) @(negedge clk);
    reset_n = 1'b1;
    repeat (10) @(negedge clk);
    t_addr();
    t_ram();
    t_block();
    t_ee();
    end_of_test();
  end

  initial begin
    repeat (90000) @(posedge clk);
    num_errors++;
    $display("BAD %0t watchdog expired", $time);
    end_of_test();
  end
endmodule

`default_nettype wire
